/* dv/tpsp_gate_model.sv */
// gate driver side of the inverter bridge: watches the six gate lines
// assumes gates are registered on clock; keeps pulse length, centre, period
module tpsp_gate_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // gate drives at the bridge
   input  wire logic [2:0]  gate_hi,
   input  wire logic [2:0]  gate_lo,
   // observations
   output logic             shoot,
   output logic [2:0][15:0] hi_len,
   output logic [2:0][15:0] mid2,
   output logic [15:0]      per_u
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0]      cyc;
   logic [2:0][15:0] rise;
   logic [2:0]       hi_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         cyc <= 0;
         shoot <= 0;
         hi_q <= 0;
         hi_len <= 0;
         mid2 <= 0;
         per_u <= 0;
      end else begin
         cyc <= cyc + 1;
         hi_q <= gate_hi;
         // both switches of a leg on would short the link
         if ((gate_hi & gate_lo) != 3'b000) shoot <= 1;
         for (int i = 0; i < 3; i++) begin
            if (gate_hi[i] && !hi_q[i]) begin
               rise[i] <= cyc;
               if (i == 0) per_u <= cyc - rise[0];
            end
            // length and centre committed together at the falling edge
            if (!gate_hi[i] && hi_q[i]) begin
               hi_len[i] <= cyc - rise[i];
               mid2[i] <= cyc + rise[i];
            end
         end
      end
   end
endmodule

/* dv/tpsp_top_tb.sv */
// bench for tpsp_top: reset, duty table, pulse widths, forced off
// assumes short carrier (40 half) and dead time 2 so the run stays brief
module tpsp_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clock = 0;
   logic             rst_b = 0;
   logic             stop_req = 0;
   logic             overcurrent = 0;
   logic [15:0]      freq_step = 16'h0000;
   logic [7:0]       mod_depth = 8'h00;
   logic [7:0]       duty_u, duty_v, duty_w;
   logic [2:0]       gate_hi, gate_lo;
   logic             shoot;
   logic [2:0][15:0] hi_len, mid2;
   logic [15:0]      per_u;
   int               miscompares = 0;
   int               n_tests = 0;
   int               cyc = 0;
   int               tcyc = 0;

   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= rst_b ? cyc + 1 : 0;
      tcyc <= tcyc + 1;
      if (tcyc == 30000) begin
         miscompares++;
         test_done();
      end
   end

   tpsp_top #(.CAR_HALF(40), .DEAD_CYC(2)) u_tpsp_top (.clock(clock), .rst_b(rst_b),
      .freq_step(freq_step), .mod_depth(mod_depth), .stop_req(stop_req),
      .overcurrent(overcurrent), .duty_u(duty_u), .duty_v(duty_v), .duty_w(duty_w),
      .gate_hi(gate_hi), .gate_lo(gate_lo));
   tpsp_gate_model u_tpsp_gate_model (.clock(clock), .rst_b(rst_b), .gate_hi(gate_hi),
      .gate_lo(gate_lo), .shoot(shoot), .hi_len(hi_len), .mid2(mid2), .per_u(per_u));

   // full-wave sine of 64 steps, rounded to 127, scaled by depth
   function automatic logic [7:0] exp_duty(input logic [23:0] acc, input logic [7:0] dp);
      real s;
      int  mag;
      s = 127.0 * $sin(3.14159265358979 * acc[23:18] / 32.0);
      mag = (s < 0) ? -$rtoi(-s + 0.5) : $rtoi(s + 0.5);
      return 8'(128 + $rtoi($floor(mag * dp / 256.0)));
   endfunction
   // upper on-time loses the dead time at its rising edge
   function automatic logic [15:0] exp_hi(input logic [7:0] d);
      return 16'(2 * ((d * 40) >> 8) - 2);
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic [15:0] st, input logic [7:0] dp);
      @(negedge clock);
      rst_b = 0;
      freq_step = st;
      mod_depth = dp;
      stop_req = 0;
      overcurrent = 0;
      repeat (6) @(negedge clock);
      chk8({2'b00, gate_hi, gate_lo}, 8'h00);
      chk8(duty_u, 8'h80);
      rst_b = 1;
   endtask
   task automatic at(input int n);
      while (cyc != n) @(negedge clock);
   endtask

   task automatic t_frozen;
      do_reset(16'h0000, 8'hFF);
      at(220);
      chk8(duty_u, exp_duty(24'h00_0000, 8'hFF));
      chk8(duty_v, exp_duty(24'h55_5555, 8'hFF));
      chk8(duty_w, exp_duty(24'hAA_AAAA, 8'hFF));
      chk16(hi_len[0], exp_hi(exp_duty(24'h00_0000, 8'hFF)));
      chk16(hi_len[1], exp_hi(exp_duty(24'h55_5555, 8'hFF)));
      chk16(hi_len[2], exp_hi(exp_duty(24'hAA_AAAA, 8'hFF)));
      chk16(mid2[1], mid2[0]);
      chk16(mid2[2], mid2[0]);
      chk16(per_u, 16'd80);
      at(460);
      chk8(duty_v, exp_duty(24'h55_5555, 8'hFF));
      chk8({7'h00, shoot}, 8'h00);
   endtask
   task automatic t_moving;
      // the 50 Hz step at a 20 kHz carrier, 3125 Hz with this short carrier, with a reduced depth, as the controller pairs them
      do_reset(16'd41943, 8'hC0);
      for (int k = 0; k < 8; k++) begin
         at(80 * k + 100);
         chk8(duty_u, exp_duty(24'(41943 * k), 8'hC0));
         chk8(duty_v, exp_duty(24'(41943 * k + 24'h55_5555), 8'hC0));
      end
   endtask
   task automatic t_zero;
      do_reset(16'hFFFF, 8'h00);
      for (int k = 0; k < 4; k++) begin
         at(80 * k + 100);
         chk8(duty_w, 8'h80);
      end
      for (int i = 0; i < 3; i++) chk16(hi_len[i], 16'd38);
   endtask
   task automatic t_force(input logic oc);
      do_reset(16'h0000, 8'h00);
      at(200);
      stop_req = !oc;
      overcurrent = oc;
      // two sync flops plus the gate register
      repeat (4) @(negedge clock);
      repeat (80) begin
         chk8({2'b00, gate_hi, gate_lo}, 8'h00);
         @(negedge clock);
      end
      stop_req = 0;
      overcurrent = 0;
      repeat (200) @(negedge clock);
      chk16(hi_len[0], 16'd38);
      chk8({7'h00, shoot}, 8'h00);
   endtask

   task automatic test_done;
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      t_frozen();
      t_moving();
      t_zero();
      t_force(1'b0);
      t_force(1'b1);
      test_done();
   end
endmodule

/* hdl/tpsp_phase.sv */
// one inverter leg: carrier compare and complementary gates with dead time
// assumes tri_cnt and thresh come from registers on the same clock
`include "tpsp_map.svh"
module tpsp_phase
   import tpsp_pkg::*;
#(
   parameter int CNT_W    = `TPSP_CNT_W,
   parameter int DEAD_CYC = 20,
   parameter int DEAD_W   = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // carrier and duty
   input  wire logic [CNT_W-1:0] tri_cnt,
   input  wire logic [CNT_W-1:0] thresh,
   input  wire logic             force_off,
   // gate drives
   output logic                  gate_hi,
   output logic                  gate_lo
);
   typedef struct packed {
      logic              hi;
      logic              lo;
      logic [DEAD_W-1:0] dead;
   } tpsp_leg_t;

   tpsp_leg_t st_reg;
   tpsp_leg_t st_next;
   logic      want;

   // valley-centred pulse: both edges move with the threshold
   assign want = tri_cnt < thresh;

   always_comb begin
      st_next = st_reg;
      if (force_off) begin
         st_next.hi   = 1'b0;
         st_next.lo   = 1'b0;
         st_next.dead = DEAD_W'(DEAD_CYC - 1);
      end else if ((st_reg.hi && !want) || (st_reg.lo && want)) begin
         st_next.hi   = 1'b0;
         st_next.lo   = 1'b0;
         st_next.dead = DEAD_W'(DEAD_CYC - 1);
      end else if (!st_reg.hi && !st_reg.lo) begin
         if (st_reg.dead != '0) begin
            st_next.dead = st_reg.dead - 1'b1;
         end else begin
            st_next.hi = want;
            st_next.lo = !want;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_reg <= '{hi: 1'b0, lo: 1'b0, dead: DEAD_W'(DEAD_CYC - 1)};
      end else begin
         st_reg <= st_next;
      end
   end

   assign gate_hi = st_reg.hi;
   assign gate_lo = st_reg.lo;

   // helper: length of the current both-off gap
   logic [DEAD_W:0] off_run;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         off_run <= '0;
      end else if (!st_reg.hi && !st_reg.lo) begin
         off_run <= (off_run == '1) ? off_run : off_run + 1'b1;
      end else begin
         off_run <= '0;
      end
   end

   no_overlap_a: assert property (@(posedge clock) disable iff (!rst_b)
      !(gate_hi && gate_lo)) else $error("both gates of one leg on");
   dead_gap_a: assert property (@(posedge clock) disable iff (!rst_b)
      ($rose(gate_hi) || $rose(gate_lo)) |-> off_run >= (DEAD_W+1)'(DEAD_CYC))
      else $error("dead time too short");
   force_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      force_off |=> !gate_hi && !gate_lo) else $error("gate on while forced off");
   gate_cov: cover property (@(posedge clock) disable iff (!rst_b) $rose(gate_hi));
endmodule

/* hdl/tpsp_top.sv */
// three-phase sine-weighted pwm generator with dead-time gate outputs
// assumes step and depth come from logic on this clock; stop and
// overcurrent are asynchronous pins
//
// Notes on behaviour
// - one stored quarter-wave sine table feeds all three phase waveforms
// - three read positions held 120 degrees apart, one per phase
// - table value scaled by modulation depth before use as duty
// - pointer advance rate sets output frequency, may be arbitrarily slow
// - stationary pointers keep pulsing at a frozen point of the wave
// - duty numbers produced at a constant rate defining the carrier period
// - carrier fixed near 20 kHz, not locked to the modulation frequency
// - one shared carrier counter turns the three duties into pulse lengths
// - double-edged modulation: both pulse edges shift symmetrically
// - zero depth gives a 50 percent square wave at the carrier
// - advance rate reaches modulation frequencies from zero to about 78 Hz
// - 8-bit duty per phase, upper on-time 0 to 255/256 of the carrier period, lower complement
// - upper and lower gates complementary with a dead-time underlap
// - stop or overcurrent forces all six gates off
// - new duties computed once per 50 us carrier period
`include "tpsp_map.svh"
module tpsp_top
   import tpsp_pkg::*;
#(
   parameter int CNT_W    = `TPSP_CNT_W,
   parameter int ACC_W    = `TPSP_ACC_W,
   parameter int CAR_HALF = `TPSP_CARRIER_NS / (2 * `TPSP_CLK_NS),
   parameter int DEAD_CYC = (`TPSP_DEAD_NS + `TPSP_CLK_NS - 1) / `TPSP_CLK_NS,
   parameter int DEAD_W   = 8
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_b,
   // speed and depth control
   input  wire logic [`TPSP_STEP_W-1:0] freq_step,
   input  wire logic [`TPSP_DUTY_W-1:0] mod_depth,
   // protection pins
   input  wire logic                    stop_req,
   input  wire logic                    overcurrent,
   // duty numbers
   output logic [`TPSP_DUTY_W-1:0]      duty_u,
   output logic [`TPSP_DUTY_W-1:0]      duty_v,
   output logic [`TPSP_DUTY_W-1:0]      duty_w,
   // gate drives
   output logic [2:0]                   gate_hi,
   output logic [2:0]                   gate_lo
);
   typedef struct packed {
      logic [CNT_W-1:0]                   cnt;
      tpsp_dir_t                          dir;
      logic [ACC_W-1:0]                   acc;
      logic [2:0][`TPSP_DUTY_W-1:0]       duty;
      logic [2:0][CNT_W-1:0]              thr;
      logic [1:0]                         stop_sy;
      logic [1:0]                         oc_sy;
   } tpsp_state_t;

   tpsp_state_t                     st_reg;
   tpsp_state_t                     st_next;
   logic                            tick;
   logic                            force_off;
   logic [2:0][`TPSP_DUTY_W-1:0]    duty_new;
   logic [2:0][CNT_W-1:0]           thr_new;

   // free-running carrier tick, never resynchronised to the wave
   assign tick      = (st_reg.dir == TPSP_DIR_UP) && (st_reg.cnt == CNT_W'(CAR_HALF - 1));
   assign force_off = st_reg.stop_sy[1] || st_reg.oc_sy[1];

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ph
         logic [ACC_W-1:0]          ptr;
         logic [CNT_W+7:0]          prod;
         assign ptr = st_reg.acc + ACC_W'(`TPSP_OFS_120 * gi);
         // one table, three readers; depth scaling inside the lookup
         assign duty_new[gi] = tpsp_duty_of(ptr[ACC_W-1 -: `TPSP_IDX_W], mod_depth);
         assign prod = st_reg.duty[gi] * (CNT_W+8)'(CAR_HALF);
         assign thr_new[gi] = prod[CNT_W+7:8];

         tpsp_phase #(
            .CNT_W    (CNT_W),
            .DEAD_CYC (DEAD_CYC),
            .DEAD_W   (DEAD_W)
         ) u_leg (
            .clock     (clock),
            .rst_b     (rst_b),
            .tri_cnt   (st_reg.cnt),
            .thresh    (st_reg.thr[gi]),
            .force_off (force_off),
            .gate_hi   (gate_hi[gi]),
            .gate_lo   (gate_lo[gi])
         );
      end
   endgenerate

   always_comb begin
      st_next = st_reg;
      // protection pins cross in through two flops
      st_next.stop_sy = {st_reg.stop_sy[0], stop_req};
      st_next.oc_sy   = {st_reg.oc_sy[0], overcurrent};
      // triangle carrier, period 2*CAR_HALF cycles
      if (st_reg.dir == TPSP_DIR_UP) begin
         if (tick) begin
            st_next.dir = TPSP_DIR_DOWN;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end else begin
         if (st_reg.cnt == '0) begin
            st_next.dir = TPSP_DIR_UP;
         end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
         end
      end
      // peak of the carrier: all legs are low here, safe to swap duty
      if (tick) begin
         st_next.acc  = st_reg.acc + ACC_W'(freq_step);
         st_next.duty = duty_new;
      end
      // threshold follows one cycle later, still before the descent crosses it
      st_next.thr = thr_new;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_reg <= '{cnt: '0, dir: TPSP_DIR_UP, acc: '0,
                     duty: {3{`TPSP_DUTY_MID}}, thr: '0, stop_sy: '0, oc_sy: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign duty_u = st_reg.duty[0];
   assign duty_v = st_reg.duty[1];
   assign duty_w = st_reg.duty[2];

   ptr_step_a: assert property (@(posedge clock) disable iff (!rst_b)
      tick |=> st_reg.acc == $past(st_reg.acc) + ACC_W'($past(freq_step)))
      else $error("pointer did not advance by step");
   ptr_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      !tick |=> $stable(st_reg.acc)) else $error("pointer moved between ticks");
   flat_duty_a: assert property (@(posedge clock) disable iff (!rst_b)
      (tick && mod_depth == '0) |=> duty_u == `TPSP_DUTY_MID && duty_v == `TPSP_DUTY_MID
      && duty_w == `TPSP_DUTY_MID) else $error("zero depth not half duty");
   duty_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      !tick |=> $stable(duty_u) && $stable(duty_v) && $stable(duty_w))
      else $error("duty changed mid period");
   carrier_bound_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_reg.cnt < CNT_W'(CAR_HALF)) else $error("carrier count out of range");
   reset_off_a: assert property (@(posedge clock)
      !rst_b |=> gate_hi == '0 && gate_lo == '0 && st_reg.acc == '0)
      else $error("outputs not cleared by reset");
   stop_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      stop_req [*3] |=> gate_hi == '0 && gate_lo == '0)
      else $error("gates on during stop");

   step_cov: cover property (@(posedge clock) disable iff (!rst_b) tick && freq_step != '0);
   freeze_cov: cover property (@(posedge clock) disable iff (!rst_b) tick && freq_step == '0);
   stop_cov: cover property (@(posedge clock) disable iff (!rst_b) $rose(force_off));
endmodule

/* inc/tpsp_map.svh */
// constants of the three-phase sine pwm generator
// assumes a single 100 MHz clock; included by package and modules
`ifndef TPSP_MAP_SVH
`define TPSP_MAP_SVH
`define TPSP_CLK_NS      10
`define TPSP_CARRIER_NS  50000
`define TPSP_DEAD_NS     200
`define TPSP_CNT_W       12
`define TPSP_ACC_W       24
`define TPSP_STEP_W      16
`define TPSP_IDX_W       6
`define TPSP_DUTY_W      8
`define TPSP_DUTY_MID    8'h80
`define TPSP_OFS_120     24'h55_5555
`define TPSP_QTR_TOP     5'h10
`define TPSP_SINE_QTR    136'h7F_7E7D_7A75_706A_625A_5147_3C31_2519_0C00
`endif

/* inc/tpsp_pkg.sv */
// types and table decoding of the three-phase sine pwm generator
// assumes tpsp_map.svh is on the include path
`include "tpsp_map.svh"
package tpsp_pkg;
   typedef enum logic {TPSP_DIR_UP, TPSP_DIR_DOWN} tpsp_dir_t;

   localparam logic [135:0] TPSP_SINE_Q = `TPSP_SINE_QTR;

   // quarter table unfolded to a full wave, then scaled by depth
   function automatic logic [7:0] tpsp_duty_of(input logic [5:0] idx,
                                               input logic [7:0] depth);
      logic        [4:0]  j;
      logic        [7:0]  mag;
      logic signed [8:0]  dev;
      logic signed [17:0] p;
      j   = idx[4] ? (`TPSP_QTR_TOP - {1'b0, idx[3:0]}) : {1'b0, idx[3:0]};
      mag = TPSP_SINE_Q[{j, 3'b000} +: 8];
      dev = idx[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
      p   = dev * $signed({1'b0, depth});
      return `TPSP_DUTY_MID + p[15:8];
   endfunction
endpackage
